// >>> logic/lcdp_decoder.sv
// Command decoder and power-save sequencer of the dot-matrix LCD controller
// How it works
// - Byte after indicator-on loads two low bits: off, 1 s, 0.5 s, steady.
// - After indicator-on every command is ignored until the indicator load byte.
// - Display-all-on while display off enters power save.
// - Power save is sleep with indicator off, standby with indicator on.
// - Display memory is kept and stays accessible in sleep and standby.
// - Display-all-off leaves power save and resumes normal operation.
// - Sleep stops the oscillator and the LCD supply.
// - Sleep stops all drive and grounds segment and common outputs.
// - Standby stops the LCD supply, oscillator keeps running.
// - Standby stops multiplexed drive, grounds outputs, keeps static indicator.
// - Reset command in standby moves the device to sleep.
// - Display-off indicator output is low during power save.
// - Byte E3 is a no-op that only ends test mode.
// - Upper nibble F enters test mode; pin reset, reset or no-op leave it.
// - AE switches display off, AF switches it on.
// - Top bits 01 load the six-bit display start line.
// - Upper nibble B loads the four-bit page address.
// - Upper nibble 1 loads column high half, nibble 0 the low half.
// - Status read gives flags in bits 6 to 4, other bits zero.
// - Data write stores and data read fetches at current page and column.
// - E0 increments column on writes only; EE restores the starting column.
// - E2 reinitialises command settings, display memory untouched.
// - Upper nibble C takes scan direction from bit 3.
`timescale 1ns/100ps
module lcdp_decoder
  import lcdp_pkg::*;
#(
  parameter int FAST_HALF = FAST_HALF_CYC,
  parameter int DEPTH     = 2
) (
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic       HOST_WR,
  input  wire logic       HOST_RD,
  input  wire logic       COMMAND_DATA_SELECT,
  input  wire logic [7:0] HOST_WDATA,
  output logic            HOST_READY,
  output logic [7:0]      RD_DATA,
  output logic            RD_VALID,
  input  wire logic [7:0] MEM_RDATA,
  output logic            MEM_WE,
  output logic            MEM_RE,
  output logic [3:0]      MEM_PAGE,
  output logic [7:0]      MEM_COL,
  output logic [7:0]      MEM_WDATA,
  output logic            DISPLAY_ON,
  output logic            ALL_ON,
  output logic [5:0]      START_LINE,
  output logic            SCAN_REVERSE,
  output logic            TEST_MODE,
  output logic [1:0]      IND_MODE,
  output logic            IND_DRIVE,
  output logic            OSC_RUN,
  output logic            SUPPLY_RUN,
  output logic            MUX_DRIVE,
  output logic            OUTPUTS_GROUNDED,
  output logic            DISPLAY_OFF_INDICATOR_N,
  output logic            SLEEP,
  output logic            STANDBY
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(FAST_HALF + 1);
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
  localparam logic [CW-1:0] DIV_LAST = CW'(FAST_HALF - 1);

  lcdp_req_t   buf_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  lcdp_state_t state_q;
  lcdp_req_t   req;
  logic        push;
  logic        pop;
  logic        cmd_go;
  logic        wr_go;
  logic        rd_go;
  logic        disp_on_q;
  logic        all_on_q;
  logic [5:0]  line_q;
  logic [3:0]  page_q;
  logic [7:0]  col_q;
  logic [7:0]  col_save_q;
  logic        rmw_q;
  logic        scan_q;
  logic        test_q;
  logic [1:0]  ind_q;
  logic        ind_wait_q;
  logic        save_q;
  logic        sleep_d;
  logic        standby_d;
  logic [CW-1:0] div_q;
  logic [1:0]  phase_q;
  logic        blink_d;

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Two-entry request buffer; the drain stalls while a memory read is outstanding
  assign push   = (HOST_WR | HOST_RD) & HOST_READY;
  assign req    = buf_q[rd_ptr_q];
  assign pop    = (count_q != '0) && (state_q == ST_IDLE);
  assign cmd_go = pop & ~req.sel & ~req.rd;
  assign wr_go  = pop & req.sel & ~req.rd;
  assign rd_go  = pop & req.rd;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (push) begin
      buf_q[wr_ptr_q] <= '{sel: COMMAND_DATA_SELECT, rd: HOST_RD, data: HOST_WDATA};
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      HOST_READY <= 1'b0;
    end else begin
      HOST_READY <= (count_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0)) < DEPTH_C;
    end
  end

  // Command execution; the indicator load byte blocks every other command
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      disp_on_q  <= 1'b0;
      all_on_q   <= 1'b0;
      line_q     <= LINE_RST;
      page_q     <= PAGE_RST;
      scan_q     <= 1'b0;
      test_q     <= 1'b0;
      ind_q      <= IND_OFF;
      ind_wait_q <= 1'b0;
      save_q     <= 1'b0;
    end else if (cmd_go) begin
      if (ind_wait_q) begin
        ind_q      <= req.data[1:0];
        ind_wait_q <= 1'b0;
      end else if (req.data[7:4] == NIB_TEST) begin
        test_q <= 1'b1;
      end else if (req.data[7:6] == TOP_START) begin
        line_q <= req.data[5:0];
      end else if (req.data[7:4] == NIB_PAGE) begin
        page_q <= req.data[3:0];
      end else if (req.data[7:4] == NIB_SCAN) begin
        scan_q <= req.data[SCAN_BIT];
      end else begin
        case (req.data)
          CMD_DISP_OFF: disp_on_q <= 1'b0;
          CMD_DISP_ON:  disp_on_q <= 1'b1;
          CMD_ALL_ON: begin
            all_on_q <= 1'b1;
            if (!disp_on_q) begin
              save_q <= 1'b1;
            end
          end
          CMD_ALL_NORM: begin
            all_on_q <= 1'b0;
            save_q   <= 1'b0;
          end
          CMD_IND_OFF: ind_q <= IND_OFF;
          CMD_IND_ON:  ind_wait_q <= 1'b1;
          CMD_NOP:     test_q <= 1'b0;
          CMD_RESET: begin
            // Settings return to reset values; power save and memory are kept
            disp_on_q <= 1'b0;
            all_on_q  <= 1'b0;
            line_q    <= LINE_RST;
            page_q    <= PAGE_RST;
            scan_q    <= 1'b0;
            test_q    <= 1'b0;
            ind_q     <= IND_OFF;
          end
          default: ;
        endcase
      end
    end
  end

  // Column address and read-modify-write
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      col_q      <= COL_RST;
      col_save_q <= COL_RST;
      rmw_q      <= 1'b0;
    end else if (cmd_go && !ind_wait_q) begin
      if (req.data[7:4] == NIB_COL_HI) begin
        col_q[7:4] <= req.data[3:0];
      end else if (req.data[7:4] == NIB_COL_LO) begin
        col_q[3:0] <= req.data[3:0];
      end else if (req.data == CMD_RMW) begin
        rmw_q      <= 1'b1;
        col_save_q <= col_q;
      end else if (req.data == CMD_END) begin
        rmw_q <= 1'b0;
        col_q <= col_save_q;
      end else if (req.data == CMD_RESET) begin
        rmw_q <= 1'b0;
        col_q <= COL_RST;
      end
    end else if (wr_go || (rd_go && req.sel && !rmw_q)) begin
      col_q <= col_q + COL_STEP;
    end
  end

  // Display memory port stays usable in power save
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      MEM_WE    <= 1'b0;
      MEM_RE    <= 1'b0;
      MEM_PAGE  <= PAGE_RST;
      MEM_COL   <= COL_RST;
      MEM_WDATA <= ZERO_BYTE;
    end else begin
      MEM_WE <= wr_go;
      MEM_RE <= rd_go & req.sel;
      if (wr_go || (rd_go && req.sel)) begin
        MEM_PAGE  <= page_q;
        MEM_COL   <= col_q;
        MEM_WDATA <= req.data;
      end
    end
  end

  // Read answers: status at once, memory data one cycle after the strobe
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q  <= ST_IDLE;
      RD_DATA  <= ZERO_BYTE;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (rd_go && req.sel) begin
            state_q <= ST_RDWAIT;
          end else if (rd_go) begin
            RD_DATA <= ZERO_BYTE;
            RD_DATA[STAT_RMW_BIT] <= rmw_q;
            RD_DATA[STAT_OFF_BIT] <= ~disp_on_q;
            RD_DATA[STAT_PS_BIT]  <= save_q;
            RD_VALID <= 1'b1;
          end
        end
        ST_RDWAIT: begin
          RD_DATA  <= MEM_RDATA;
          RD_VALID <= 1'b1;
          state_q  <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Blink divider runs from the oscillator, so it halts in sleep
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      div_q   <= '0;
      phase_q <= 2'h0;
    end else if (!sleep_d) begin
      if (div_q == DIV_LAST) begin
        div_q   <= '0;
        phase_q <= phase_q + 2'h1;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  assign sleep_d   = save_q & (ind_q == IND_OFF);
  assign standby_d = save_q & (ind_q != IND_OFF);

  always_comb begin
    case (ind_q)
      IND_SLOW:   blink_d = phase_q[1];
      IND_FAST:   blink_d = phase_q[0];
      IND_STEADY: blink_d = 1'b1;
      default:    blink_d = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      OSC_RUN                 <= 1'b1;
      SUPPLY_RUN              <= 1'b1;
      MUX_DRIVE               <= 1'b1;
      OUTPUTS_GROUNDED        <= 1'b0;
      DISPLAY_OFF_INDICATOR_N <= 1'b1;
      SLEEP                   <= 1'b0;
      STANDBY                 <= 1'b0;
      IND_DRIVE               <= 1'b0;
    end else begin
      OSC_RUN                 <= ~sleep_d;
      SUPPLY_RUN              <= ~save_q;
      MUX_DRIVE               <= ~save_q;
      OUTPUTS_GROUNDED        <= save_q;
      DISPLAY_OFF_INDICATOR_N <= ~save_q;
      SLEEP                   <= sleep_d;
      STANDBY                 <= standby_d;
      IND_DRIVE               <= blink_d & ~sleep_d;
    end
  end

  assign DISPLAY_ON   = disp_on_q;
  assign ALL_ON       = all_on_q;
  assign START_LINE   = line_q;
  assign SCAN_REVERSE = scan_q;
  assign TEST_MODE    = test_q;
  assign IND_MODE     = ind_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence cmd_s(logic [7:0] c);
    cmd_go && !ind_wait_q && req.data == c;
  endsequence

  enter_save_a: assert property (cmd_s(CMD_ALL_ON) ##0 !disp_on_q |=> save_q ##1 !DISPLAY_OFF_INDICATOR_N)
    else $error("power save not entered");
  leave_save_a: assert property (cmd_s(CMD_ALL_NORM) |=> !save_q ##1 MUX_DRIVE && SUPPLY_RUN)
    else $error("power save not left");
  ind_load_a: assert property (cmd_go && ind_wait_q |=> ind_q == $past(req.data[1:0]) && !ind_wait_q)
    else $error("indicator load wrong");
  ind_block_a: assert property (cmd_go && ind_wait_q |=> $stable(disp_on_q) && $stable(page_q) && $stable(save_q))
    else $error("command not ignored during indicator load");
  sleep_mode_a: assert property (save_q && ind_q == IND_OFF && $stable(save_q) && $stable(ind_q)
    |=> SLEEP && !OSC_RUN && !SUPPLY_RUN && OUTPUTS_GROUNDED && !IND_DRIVE)
    else $error("sleep outputs wrong");
  standby_mode_a: assert property (save_q && ind_q != IND_OFF && $stable(save_q) && $stable(ind_q)
    |=> STANDBY && OSC_RUN && !SUPPLY_RUN && !MUX_DRIVE)
    else $error("standby outputs wrong");
  reset_standby_a: assert property (save_q && ind_q != IND_OFF ##0 cmd_s(CMD_RESET) |=> save_q ##1 SLEEP)
    else $error("reset in standby not sleep");
  test_exit_a: assert property (cmd_s(CMD_NOP) |=> !test_q && $stable(page_q) && $stable(col_q))
    else $error("no-op changed state");
  test_enter_a: assert property (cmd_go && !ind_wait_q && req.data[7:4] == NIB_TEST |=> test_q)
    else $error("test mode not entered");
  rmw_read_a: assert property (rmw_q && rd_go && req.sel |=> $stable(col_q) ##1 RD_VALID)
    else $error("column moved on read in rmw");
  status_zero_a: assert property (rd_go && !req.sel |=> RD_VALID && RD_DATA[7] == 1'b0 && RD_DATA[3:0] == 4'h0)
    else $error("status reserved bits not zero");
  mem_write_a: assert property (wr_go |=> MEM_WE && MEM_WDATA == $past(req.data) && MEM_COL == $past(col_q))
    else $error("memory write wrong");
endmodule

// >>> logic/lcdp_pkg.sv
// Command codes, field positions, timing and carrier types for the LCD command decoder
package lcdp_pkg;
  localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON  = 8'hAF;
  localparam logic [7:0] CMD_ALL_NORM = 8'hA4;
  localparam logic [7:0] CMD_ALL_ON   = 8'hA5;
  localparam logic [7:0] CMD_IND_OFF  = 8'hAC;
  localparam logic [7:0] CMD_IND_ON   = 8'hAD;
  localparam logic [7:0] CMD_RMW      = 8'hE0;
  localparam logic [7:0] CMD_END      = 8'hEE;
  localparam logic [7:0] CMD_RESET    = 8'hE2;
  localparam logic [7:0] CMD_NOP      = 8'hE3;
  localparam logic [3:0] NIB_PAGE     = 4'hB;
  localparam logic [3:0] NIB_COL_HI   = 4'h1;
  localparam logic [3:0] NIB_COL_LO   = 4'h0;
  localparam logic [3:0] NIB_SCAN     = 4'hC;
  localparam logic [3:0] NIB_TEST     = 4'hF;
  localparam logic [1:0] TOP_START    = 2'h1;
  localparam int         SCAN_BIT     = 3;
  localparam logic [1:0] IND_OFF      = 2'h0;
  localparam logic [1:0] IND_SLOW     = 2'h1;
  localparam logic [1:0] IND_FAST     = 2'h2;
  localparam logic [1:0] IND_STEADY   = 2'h3;
  localparam int         STAT_RMW_BIT = 6;
  localparam int         STAT_OFF_BIT = 5;
  localparam int         STAT_PS_BIT  = 4;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam logic [5:0] LINE_RST     = 6'h00;
  localparam logic [3:0] PAGE_RST     = 4'h0;
  localparam logic [7:0] COL_RST      = 8'h00;
  localparam logic [7:0] COL_STEP     = 8'h01;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         BLINK_FAST_MS = 500;
  localparam int         FAST_HALF_CYC = BLINK_FAST_MS * 1000000 / CLK_PERIOD_NS / 2;
  typedef struct packed {
    logic       sel;
    logic       rd;
    logic [7:0] data;
  } lcdp_req_t;
  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_RDWAIT = 1'b1
  } lcdp_state_t;
endpackage

// >>> tb/lcdp_mem_model.sv
// Display memory model answering the decoder's memory port
`timescale 1ns/100ps
module lcdp_mem_model (
  input  wire logic       MCLK,
  input  wire logic       MEM_WE,
  input  wire logic       MEM_RE,
  input  wire logic [3:0] MEM_PAGE,
  input  wire logic [7:0] MEM_COL,
  input  wire logic [7:0] MEM_WDATA,
  output logic      [7:0] MEM_RDATA
);
  logic [7:0] ram [0:4095];
  always @(posedge MCLK) begin
    if (MEM_WE === 1'b1) ram[{MEM_PAGE, MEM_COL}] <= MEM_WDATA;
  end
  // Outside a read strobe the bus shows inverted data so a late sample is caught
  assign MEM_RDATA = (MEM_RE === 1'b1) ? ram[{MEM_PAGE, MEM_COL}] : ~ram[{MEM_PAGE, MEM_COL}];
endmodule

// >>> tb/lcd_command_decoder_power_save_tb_top.sv
// Self-checking bench of the LCD command decoder against a behavioural model
`timescale 1ns/100ps
module lcd_command_decoder_power_save_tb_top;
  import lcdp_pkg::*;
  localparam int FH = 4;
  localparam int DON = 0, AON = 1, SL = 2, SCR = 3, TM = 4, IND = 5;
  localparam int PEND = 6, RMW = 7, PS = 8, PG = 9, COL = 10, SAV = 11;
  logic        clk, rst, wr, rd, cds, rdy, rvld, mwe, mre;
  logic [7:0]  wd, rdat, mrd, mcol, mwd;
  logic [3:0]  mpg;
  logic [5:0]  sl;
  logic [1:0]  im;
  logic        don, aon, scr, tm, idr, osc, sup, mux, gnd, dof_n, slp, stb;
  int          m [12];
  int          mem [int];
  int          seed = 22;
  int          err_count = 0;
  int          num_checks = 0;
  logic [7:0]  rq [$];
  logic [7:0]  tbl [12] = '{8'hAF, 8'hA5, 8'hA4, 8'h6B, 8'hBC, 8'h1A, 8'h07, 8'hC8, 8'hC7, 8'h2F, 8'hE2, 8'hAE};
  wire  [18:0] act = {don, aon, sl, scr, tm, im, slp, stb, dof_n, osc, sup, mux, gnd};

  lcdp_decoder #(.FAST_HALF(FH), .DEPTH(2)) u_lcdp_decoder (
    .MCLK(clk), .RST(rst), .HOST_WR(wr), .HOST_RD(rd), .COMMAND_DATA_SELECT(cds),
    .HOST_WDATA(wd), .HOST_READY(rdy), .RD_DATA(rdat), .RD_VALID(rvld), .MEM_RDATA(mrd),
    .MEM_WE(mwe), .MEM_RE(mre), .MEM_PAGE(mpg), .MEM_COL(mcol), .MEM_WDATA(mwd),
    .DISPLAY_ON(don), .ALL_ON(aon), .START_LINE(sl), .SCAN_REVERSE(scr), .TEST_MODE(tm),
    .IND_MODE(im), .IND_DRIVE(idr), .OSC_RUN(osc), .SUPPLY_RUN(sup), .MUX_DRIVE(mux),
    .OUTPUTS_GROUNDED(gnd), .DISPLAY_OFF_INDICATOR_N(dof_n), .SLEEP(slp), .STANDBY(stb)
  );
  lcdp_mem_model u_lcdp_mem_model (
    .MCLK(clk), .MEM_WE(mwe), .MEM_RE(mre), .MEM_PAGE(mpg), .MEM_COL(mcol),
    .MEM_WDATA(mwd), .MEM_RDATA(mrd)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (rvld === 1'b1) rq.push_back(rdat);
  end

  function automatic logic [18:0] expv();
    logic p, s;
    p = 1'(m[PS]);
    s = p && m[IND] == 0;
    return {1'(m[DON]), 1'(m[AON]), 6'(m[SL]), 1'(m[SCR]), 1'(m[TM]), 2'(m[IND]), s, p && !s, !p, !s, !p, !p, p};
  endfunction

  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    num_checks++;
    if (a !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic mdl(input logic s, input logic [7:0] d);
    int t;
    t = m[PS];
    if (s) begin
      mem[m[PG] * 256 + m[COL]] = d;
      m[COL] = (m[COL] + 1) % 256;
    end else if (m[PEND] != 0) begin
      m[IND] = d[1:0];
      m[PEND] = 0;
    end else case (d)
      CMD_DISP_OFF: m[DON] = 0;
      CMD_DISP_ON:  m[DON] = 1;
      CMD_ALL_NORM: begin
        m[AON] = 0;
        m[PS] = 0;
      end
      CMD_ALL_ON: begin
        m[AON] = 1;
        if (m[DON] == 0) m[PS] = 1;
      end
      CMD_IND_OFF: m[IND] = 0;
      CMD_IND_ON:  m[PEND] = 1;
      CMD_RMW: begin
        m[RMW] = 1;
        m[SAV] = m[COL];
      end
      CMD_END: begin
        m[RMW] = 0;
        m[COL] = m[SAV];
      end
      CMD_RESET: begin
        foreach (m[i]) m[i] = 0;
        m[PS] = t;
      end
      CMD_NOP: m[TM] = 0;
      default: begin
        if (d[7:6] == TOP_START) m[SL] = d[5:0];
        else if (d[7:4] == NIB_PAGE) m[PG] = d[3:0];
        else if (d[7:4] == NIB_COL_HI) m[COL] = d[3:0] * 16 + m[COL] % 16;
        else if (d[7:4] == NIB_COL_LO) m[COL] = m[COL] / 16 * 16 + d[3:0];
        else if (d[7:4] == NIB_SCAN) m[SCR] = d[SCAN_BIT];
        else if (d[7:4] == NIB_TEST) m[TM] = 1;
      end
    endcase
  endtask

  task automatic req(input logic s, input logic r, input logic [7:0] d);
    int n;
    n = 0;
    cds = s;
    rd = r;
    wr = !r;
    wd = d;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask

  task automatic cmd(input logic s, input logic [7:0] d);
    req(s, 1'b0, d);
    mdl(s, d);
    repeat (4) @(posedge clk);
    #1;
    if (m[PEND] == 0) chk(expv(), act);
  endtask

  task automatic rdchk(input logic s, input int e);
    int n;
    n = 0;
    rq.delete();
    req(s, 1'b1, 8'h00);
    while (rq.size() == 0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk(e, rq.size() > 0 ? 32'(rq[0]) : 32'hDEAD);
    if (s && m[RMW] == 0) m[COL] = (m[COL] + 1) % 256;
  endtask

  task automatic mrdk();
    rdchk(1'b1, mem[m[PG] * 256 + m[COL]]);
  endtask

  task automatic pin_reset();
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (m[i]) m[i] = 0;
    repeat (2) @(posedge clk);
    #1;
    chk(expv(), act);
  endtask

  // Holds the write strobe up and counts the cycles the buffer refuses
  task automatic burst(input int n);
    int k, r;
    logic t;
    k = 0;
    r = 0;
    cds = 1'b1;
    wr = 1'b1;
    wd = 8'($random(seed));
    while (k < n) begin
      @(negedge clk);
      t = (rdy === 1'b1);
      r += int'(!t);
      @(posedge clk);
      #1;
      if (t) begin
        mdl(1'b1, wd);
        k++;
        wd = 8'($random(seed));
      end
    end
    wr = 1'b0;
    @(posedge clk);
    #1;
    $display("burst of %0d words, %0d refused cycles", n, r);
    chk(0, r);
  endtask

  task automatic blink(input int e);
    int t;
    logic p;
    t = 0;
    p = idr;
    repeat (64) begin
      @(posedge clk);
      #1;
      if (idr !== p) t++;
      p = idr;
    end
    chk(1, 32'(t >= e - 1 && t <= e + 1));
  endtask

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    cds = 1'b0;
    wd = 8'h00;
    pin_reset();
    rdchk(1'b0, 32'h20);
    foreach (tbl[i]) cmd(1'b0, tbl[i]);
    cmd(1'b0, {2'h1, 6'($random(seed))});
    $display("test decode done, checks %0d", num_checks);
    cmd(1'b0, 8'hB3);
    cmd(1'b0, 8'h12);
    cmd(1'b0, 8'h05);
    repeat (4) cmd(1'b1, 8'($random(seed)));
    burst(6);
    cmd(1'b0, 8'h12);
    cmd(1'b0, 8'h05);
    repeat (10) mrdk();
    cmd(1'b0, 8'h07);
    cmd(1'b0, CMD_RMW);
    mrdk();
    rdchk(1'b0, 32'h60);
    repeat (2) cmd(1'b1, 8'($random(seed)));
    cmd(1'b0, CMD_END);
    repeat (3) mrdk();
    $display("test data done, checks %0d", num_checks);
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, CMD_IND_ON);
      cmd(1'b0, {6'($random(seed)), 2'(i)});
      if (i == 1 || i == 2) blink(i == 1 ? 8 : 16);
      else chk(i == 3, idr);
    end
    cmd(1'b0, CMD_IND_OFF);
    $display("test indicator done, checks %0d", num_checks);
    for (int j = 0; j < 2; j++) begin
      cmd(1'b0, CMD_DISP_OFF);
      cmd(1'b0, CMD_IND_ON);
      // Load bytes that would change state if taken as commands
      cmd(1'b0, j ? 8'hAF : 8'hC8);
      cmd(1'b0, CMD_ALL_ON);
      rdchk(1'b0, 32'h30);
      cmd(1'b0, 8'h10);
      cmd(1'b0, 8'h00);
      cmd(1'b1, 8'($random(seed)));
      cmd(1'b0, 8'h00);
      mrdk();
      cmd(1'b0, CMD_DISP_ON);
      chk(j, idr);
      if (j) cmd(1'b0, CMD_RESET);
      chk(0, idr);
      cmd(1'b0, CMD_ALL_NORM);
    end
    $display("test power save done, checks %0d", num_checks);
    for (int k = 0; k < 3; k++) begin
      cmd(1'b0, {NIB_TEST, 4'($random(seed))});
      if (k == 2) pin_reset();
      else cmd(1'b0, k ? CMD_RESET : CMD_NOP);
    end
    $display("test test-mode done, checks %0d", num_checks);
    complete_run();
  end

  initial begin
    #300000;
    err_count++;
    complete_run();
  end
endmodule
